//--- core/framer_device.sv
/*
 Device end: parses command frames, checks them, writes or reads back
 a small register file and sends response frames.
 Assumes the host waits for each reply before the next command.
*/
// Implementation choice: the plain strobed port.
// Operation
// RL1 - Transmit only after a received command
// RL2 - Host waits for reply or timeout
// RL3 - Quiet write is write, answered is read
// RL4 - Fields: init, id, address, data, check
// RL5 - Init byte first, sets frame length
// RL6 - Bit 7 one command, zero response
// RL7 - Bits 6..4 select request kind
// RL8 - Bit 3 selects 8 or 16 bit address
// RL9 - Bits 2..0 length, 111 means eight
// RL10 - Response init holds data count minus one
// RL11 - Act only on matching node or group
// RL12 - Broadcast omits identifier byte
// RL13 - Short address implies upper byte zero
// RL14 - Sixteen bit check code, LSB first
// RL15 - Residue over whole frame must be zero
// RL16 - Drop reserved kinds silently
`timescale 1ns/1ns
module framer_device (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, low
  framer_link.dev link, // Link to host
  output logic [7:0] node_address, // Own node address
  output logic [7:0] group_identifier, // Own group
  output logic frame_good, // Pulse: frame accepted
  output logic frame_error // Pulse: check code failed
);
  typedef enum logic [7:0] {
    s_idle = 8'h01,
    s_ident = 8'h02,
    s_ahi = 8'h04,
    s_alo = 8'h08,
    s_data = 8'h10,
    s_crc1 = 8'h20,
    s_crc2 = 8'h40,
    s_reply = 8'h80
  } dev_state_t;

  dev_state_t state; // Frame state
  dev_state_t next_state; // Next frame state
  logic [2:0] kind; // Request kind
  logic wide; // 16-bit address
  logic [3:0] len; // Payload byte count
  logic [3:0] cnt; // Payload index
  logic [7:0] ident; // Received identifier
  logic [15:0] addr; // Register address
  logic [7:0] pay [0:7]; // Payload bytes
  logic [7:0] regs [0:framer_pkg::REG_COUNT-1]; // Register file
  logic [3:0] reply_n; // Reply data bytes
  logic [3:0] rcnt; // Reply byte index
  logic [7:0] crc_hi; // Latched high check byte
  logic [15:0] crc; // Check register
  logic [15:0] crc_next; // Check after this byte

  wire rx = link.cmd_valid; // Byte arrives
  wire [7:0] b = link.cmd_byte; // Byte value
  wire is_bcast = kind[2]; // No identifier field
  // RL16 reserved kind codes
  wire reserved = (kind == framer_pkg::kind_rsvd4) || (kind == framer_pkg::kind_rsvd5);
  // RL3 answered kinds are reads
  wire with_rsp = ~kind[0];
  // RL11 identifier match
  wire hit = is_bcast || (kind[1] ? (ident == group_identifier) : (ident == node_address));
  // RL15 zero residue after last check byte
  wire good = (crc_next == 16'h0000);
  wire last_crc = (state == s_crc2) && rx; // Frame ends now
  wire accept = last_crc && good && hit && !reserved; // Act on frame
  wire apply = accept && !with_rsp; // Perform write
  wire short_addr = (addr[15:4] == 12'h000); // Inside register file
  wire [4:0] rd_sum = {1'b0, addr[3:0]} + {1'b0, rcnt} - 5'h01; // Read index
  wire [7:0] rd_byte = (short_addr && !rd_sum[4]) ? regs[rd_sum[3:0]] : 8'h00;
  wire [3:0] n_req = (len == 4'h0) ? 4'h1 : ({1'b0, pay[0][2:0]} + 4'h1); // Reply size
  wire in_reply = (state == s_reply); // Sending
  wire crc_feed_tx = in_reply && (rcnt <= reply_n); // Fold init and data
  wire crc_feed_rx = rx && (state != s_reply); // Fold received bytes
  wire start = (state == s_idle) && rx && b[framer_pkg::FRAME_KIND_BIT];
  logic [7:0] tx_sel; // Byte to send

  // RL10 reply byte selection
  always_comb
  begin
    if (rcnt == 4'h0)
      tx_sel = {1'b0, 3'h0, reply_n - 4'h1};
    else if (rcnt <= reply_n)
      tx_sel = rd_byte;
    else if (rcnt == reply_n + 4'h1)
      tx_sel = crc[7:0];
    else
      tx_sel = crc_hi;
  end

  // RL14 check code over sent or received bytes
  crc16_step u_crc (
    .clk(clk),
    .rstn(rstn),
    .clear(start),
    .feed(in_reply ? crc_feed_tx : (crc_feed_rx && (state != s_idle || start))),
    .data(in_reply ? tx_sel : b),
    .crc(crc),
    .crc_next(crc_next)
  );

  // Frame sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      s_idle:
        // RL5 RL6 only a command init opens a frame
        if (start)
          // RL12 broadcast skips identifier
          next_state = b[6] ? (b[framer_pkg::WIDE_BIT] ? s_ahi : s_alo) : s_ident;
      s_ident:
        if (rx)
          next_state = wide ? s_ahi : s_alo;
      s_ahi:
        if (rx)
          next_state = s_alo;
      s_alo:
        if (rx)
          next_state = (len == 4'h0) ? s_crc1 : s_data;
      s_data:
        if (rx && (cnt == len - 4'h1))
          next_state = s_crc1;
      s_crc1:
        if (rx)
          next_state = s_crc2;
      s_crc2:
        // RL1 reply only to an accepted read
        if (rx)
          next_state = (accept && with_rsp) ? s_reply : s_idle;
      s_reply:
        if (rcnt == reply_n + 4'h2)
          next_state = s_idle;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= s_idle;
    else
      state <= next_state;
  end

  // Header capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      kind <= 3'h0;
      wide <= 1'b0;
      len <= 4'h0;
      ident <= 8'h00;
      addr <= 16'h0000;
    end
    else if (start)
    begin
      // RL7 RL8 RL9 init byte fields
      kind <= b[framer_pkg::KIND_MSB:framer_pkg::KIND_LSB];
      wide <= b[framer_pkg::WIDE_BIT];
      len <= framer_pkg::payload_count(b[framer_pkg::LEN_MSB:0]);
      // RL13 upper address defaults to zero
      addr <= 16'h0000;
    end
    else if (rx && state == s_ident)
      ident <= b;
    else if (rx && state == s_ahi)
      addr[15:8] <= b;
    else if (rx && state == s_alo)
      addr[7:0] <= b;
  end

  // Payload capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= 4'h0;
    else if (start)
      cnt <= 4'h0;
    else if (rx && state == s_data)
      cnt <= cnt + 4'h1;
  end

  genvar p;
  generate
    for (p = 0; p < 8; p++)
    begin : g_pay
      // Payload byte slot
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          pay[p] <= 8'h00;
        else if (rx && state == s_data && cnt[2:0] == p[2:0])
          pay[p] <= b;
      end
    end
  endgenerate

  // Register file with burst write
  genvar r;
  generate
    for (r = 0; r < framer_pkg::REG_COUNT; r++)
    begin : g_reg
      wire [4:0] off = {1'b0, r[3:0]} - {1'b0, addr[3:0]}; // Offset in burst
      wire wr_here = apply && short_addr && !off[4] && (off[3:0] < len);
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          regs[r] <= framer_pkg::REG_RST;
        else if (wr_here)
          regs[r] <= pay[off[2:0]];
      end
    end
  endgenerate

  assign node_address = regs[framer_pkg::NODE_ADDRESS_OFS];
  assign group_identifier = regs[framer_pkg::GROUP_IDENTIFIER_OFS];

  // Reply counters
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reply_n <= 4'h1;
      rcnt <= 4'h0;
      crc_hi <= 8'h00;
    end
    else if (accept && with_rsp)
    begin
      reply_n <= n_req;
      rcnt <= 4'h0;
    end
    else if (in_reply)
    begin
      rcnt <= rcnt + 4'h1;
      if (rcnt == reply_n + 4'h1)
        crc_hi <= crc[15:8];
    end
  end

  // Link and status outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.rsp_valid <= 1'b0;
      link.rsp_byte <= 8'h00;
      frame_good <= 1'b0;
      frame_error <= 1'b0;
    end
    else
    begin
      link.rsp_valid <= in_reply;
      link.rsp_byte <= in_reply ? tx_sel : 8'h00;
      frame_good <= accept;
      // RL15 bad residue flagged
      frame_error <= last_crc && !good;
    end
  end
endmodule : framer_device

//--- core/framer_pkg.sv
/*
 Shared constants and types for the command/response framer.
 Assumes one 20 MHz clock and a byte-wide link between host and device.
*/
package framer_pkg;
  // Clock
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 50;
  // Host reply timeout, in microseconds, and its cycle count
  localparam int REPLY_TIMEOUT_US = 1000;
  localparam int REPLY_TIMEOUT_CYCLES = REPLY_TIMEOUT_US * CLK_MHZ;
  // Init byte field positions
  localparam int FRAME_KIND_BIT = 7;
  localparam int KIND_MSB = 6;
  localparam int KIND_LSB = 4;
  localparam int WIDE_BIT = 3;
  localparam int LEN_MSB = 2;
  // Device register file
  localparam int REG_COUNT = 16;
  localparam logic [3:0] NODE_ADDRESS_OFS = 4'hA;
  localparam logic [3:0] GROUP_IDENTIFIER_OFS = 4'hB;
  localparam logic [7:0] REG_RST = 8'h00;
  // Check code
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Host register offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] TARGET_OFS = 4'h1;
  localparam logic [3:0] PAY_LO_OFS = 4'h2;
  localparam logic [3:0] PAY_HI_OFS = 4'h3;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] REPLY_LO_OFS = 4'h5;
  localparam logic [3:0] REPLY_HI_OFS = 4'h6;
  localparam int START_BIT = 7;
  // Request kinds
  typedef enum logic [2:0] {
    single_rsp = 3'h0,
    single_quiet = 3'h1,
    group_rsp = 3'h2,
    group_quiet = 3'h3,
    kind_rsvd4 = 3'h4,
    kind_rsvd5 = 3'h5,
    bcast_rsp = 3'h6,
    bcast_quiet = 3'h7
  } req_kind_t;

  // Length code to payload byte count
  function automatic logic [3:0] payload_count(input logic [2:0] code);
    payload_count = (code == 3'h7) ? 4'h8 : {1'b0, code};
  endfunction : payload_count
endpackage : framer_pkg

//--- core/framer_link.sv
/*
 Byte link between host and device.
 Assumes both ends share clk; each valid is a one-cycle byte strobe.
*/
`timescale 1ns/1ns
interface framer_link;
  logic cmd_valid; // Host byte strobe
  logic [7:0] cmd_byte; // Host byte
  logic rsp_valid; // Device byte strobe
  logic [7:0] rsp_byte; // Device byte
  modport dev (input cmd_valid, input cmd_byte, output rsp_valid, output rsp_byte);
  modport host (output cmd_valid, output cmd_byte, input rsp_valid, input rsp_byte);
endinterface : framer_link

//--- core/crc16_step.sv
/*
 Byte-wide check code register, bits taken LSB first.
 Assumes clear and feed come from logic on clk.
*/
`timescale 1ns/1ns
module crc16_step (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, low
  input wire logic clear, // Restart from zero
  input wire logic feed, // Take data this cycle
  input wire logic [7:0] data, // Byte to fold in
  output logic [15:0] crc, // Current value
  output logic [15:0] crc_next // Value after this cycle
);
  logic [15:0] st [0:8]; // Per-bit chain

  // Start point of the chain
  assign st[0] = clear ? framer_pkg::CRC_INIT : crc;

  // One shift stage per data bit
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      assign st[i+1] = {1'b0, st[i][15:1]} ^
        ((st[i][0] ^ data[i]) ? framer_pkg::CRC_POLY : 16'h0000);
    end
  endgenerate

  assign crc_next = feed ? st[8] : st[0];

  // Hold value
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      crc <= framer_pkg::CRC_INIT;
    else
      crc <= crc_next;
  end
endmodule : crc16_step

//--- core/framer_host.sv
/*
 Host end: builds command frames from its registers, sends them,
 then, for answered kinds, collects one response frame or times out.
 Assumes a plain register port and the device on the same clock.
*/
`timescale 1ns/1ns
module framer_host #(
  parameter int TIMEOUT_CYCLES = framer_pkg::REPLY_TIMEOUT_CYCLES // Reply wait
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, low
  framer_link.host link, // Link to device
  input wire logic [3:0] addr, // Register index
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata // Read data, next cycle
);
  typedef enum logic [10:0] {
    h_idle = 11'h001, h_init = 11'h002, h_ident = 11'h004, h_ahi = 11'h008,
    h_alo = 11'h010, h_data = 11'h020, h_crc1 = 11'h040, h_crc2 = 11'h080,
    h_wait = 11'h100, h_rdata = 11'h200, h_rcrc = 11'h400
  } host_state_t;

  host_state_t state; // Host state
  logic [7:0] ctrl; // Kind, width, length code
  logic [23:0] target; // Register address and identifier
  logic [63:0] payload; // Command payload
  logic [63:0] reply; // Reply data
  logic [3:0] cnt; // Payload index
  logic [6:0] rlm1; // Reply length minus one
  logic [6:0] rcnt; // Reply index
  logic rc2; // Second check byte due
  logic [7:0] crc_hi; // Latched high check byte
  logic [31:0] tcnt; // Timeout counter
  logic ok, err, tmo; // Sticky result flags
  logic [15:0] crc; // Check register
  logic [15:0] crc_next; // Check after this byte
  logic [7:0] tx_sel; // Byte to send

  wire start = wr && (addr == framer_pkg::CTRL_OFS) && wdata[framer_pkg::START_BIT]
    && (state == h_idle);
  wire [3:0] len = framer_pkg::payload_count(ctrl[2:0]); // Payload count
  wire rx = link.rsp_valid; // Reply byte arrives
  wire rx_state = (state == h_wait) || (state == h_rdata) || (state == h_rcrc);
  wire sending = (state != h_idle) && !rx_state; // Frame going out
  wire timed_out = rx_state && (tcnt == TIMEOUT_CYCLES - 1);
  wire rx_init = (state == h_wait) && rx && !link.rsp_byte[framer_pkg::FRAME_KIND_BIT];

  // RL4 field order of the outgoing frame
  always_comb
  begin
    unique case (state)
      h_init: tx_sel = {1'b1, ctrl[6:0]};
      h_ident: tx_sel = target[7:0];
      h_ahi: tx_sel = target[23:16];
      h_alo: tx_sel = target[15:8];
      h_data: tx_sel = payload[8*cnt[2:0] +: 8];
      h_crc1: tx_sel = crc[7:0];
      default: tx_sel = crc_hi;
    endcase
  end

  // RL14 one check register, used to send then to receive
  crc16_step u_crc (
    .clk(clk),
    .rstn(rstn),
    .clear((state == h_init) || rx_init),
    .feed(sending ? (state != h_crc1 && state != h_crc2) : (rx && rx_state)),
    .data(sending ? tx_sel : link.rsp_byte),
    .crc(crc),
    .crc_next(crc_next)
  );

  // Sequencing and capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= h_idle;
      cnt <= 4'h0;
      rcnt <= 7'h00;
      rlm1 <= 7'h00;
      rc2 <= 1'b0;
      crc_hi <= 8'h00;
      tcnt <= 32'h0;
      reply <= 64'h0;
    end
    else
    begin
      tcnt <= rx_state ? tcnt + 32'h1 : 32'h0;
      unique case (state)
        h_idle:
          if (start)
            state <= h_init;
        h_init:
          // RL12 broadcast has no identifier
          state <= ctrl[6] ? (ctrl[3] ? h_ahi : h_alo) : h_ident;
        h_ident:
          // RL8 RL13 short address sends one byte
          state <= ctrl[3] ? h_ahi : h_alo;
        h_ahi:
          state <= h_alo;
        h_alo:
        begin
          cnt <= 4'h0;
          state <= (len == 4'h0) ? h_crc1 : h_data;
        end
        h_data:
        begin
          cnt <= cnt + 4'h1;
          if (cnt == len - 4'h1)
            state <= h_crc1;
        end
        h_crc1:
        begin
          crc_hi <= crc[15:8];
          state <= h_crc2;
        end
        h_crc2:
          // RL2 RL3 wait only for answered kinds
          state <= ctrl[4] ? h_idle : h_wait;
        default:
          if (timed_out)
            state <= h_idle;
          else if (rx_init)
          begin
            // RL10 reply length from init byte
            rlm1 <= link.rsp_byte[6:0];
            rcnt <= 7'h00;
            reply <= 64'h0;
            state <= h_rdata;
          end
          else if (rx && state == h_rdata)
          begin
            if (rcnt < 7'h08)
              reply[8*rcnt[2:0] +: 8] <= link.rsp_byte;
            rcnt <= rcnt + 7'h01;
            rc2 <= 1'b0;
            if (rcnt == rlm1)
              state <= h_rcrc;
          end
          else if (rx && state == h_rcrc)
          begin
            rc2 <= 1'b1;
            if (rc2)
              state <= h_idle;
          end
      endcase
    end
  end

  // Link drive and result flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.cmd_valid <= 1'b0;
      link.cmd_byte <= 8'h00;
      ok <= 1'b0;
      err <= 1'b0;
      tmo <= 1'b0;
    end
    else
    begin
      link.cmd_valid <= sending;
      link.cmd_byte <= sending ? tx_sel : 8'h00;
      if (start)
      begin
        ok <= 1'b0;
        err <= 1'b0;
        tmo <= 1'b0;
      end
      else if (rx && state == h_rcrc && rc2)
      begin
        // RL15 residue decides good or error
        ok <= (crc_next == 16'h0000);
        err <= (crc_next != 16'h0000);
      end
      else if (timed_out)
        tmo <= 1'b1;
    end
  end

  // Register writes and reads
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= 8'h00;
      target <= 24'h0;
      payload <= 64'h0;
      rdata <= 32'h0;
    end
    else
    begin
      if (start)
        ctrl <= wdata[7:0];
      if (wr && addr == framer_pkg::TARGET_OFS && state == h_idle)
        target <= wdata[23:0];
      if (wr && addr == framer_pkg::PAY_LO_OFS && state == h_idle)
        payload[31:0] <= wdata;
      if (wr && addr == framer_pkg::PAY_HI_OFS && state == h_idle)
        payload[63:32] <= wdata;
      if (!rd)
        rdata <= 32'h0;
      else
        unique case (addr)
          framer_pkg::CTRL_OFS: rdata <= {24'h0, 1'b0, ctrl[6:0]};
          framer_pkg::TARGET_OFS: rdata <= {8'h00, target};
          framer_pkg::PAY_LO_OFS: rdata <= payload[31:0];
          framer_pkg::PAY_HI_OFS: rdata <= payload[63:32];
          framer_pkg::STATUS_OFS: rdata <= {17'h0, rlm1, 4'h0, tmo, err, ok, state != h_idle};
          framer_pkg::REPLY_LO_OFS: rdata <= reply[31:0];
          framer_pkg::REPLY_HI_OFS: rdata <= reply[63:32];
          default: rdata <= 32'h0;
        endcase
    end
  end
endmodule : framer_host

//--- tb/framer_assertions.sv
/*
 Checker on the framer link and the device outputs.
 Assumes one clock; instantiated beside the link in the testbench.
*/
`timescale 1ns/1ns
module framer_assertions (
  input wire logic clk, // Clock
  input wire logic rstn, // Async reset, low
  input wire logic cmd_valid, // Host byte strobe
  input wire logic [7:0] cmd_byte, // Host byte
  input wire logic rsp_valid, // Device byte strobe
  input wire logic [7:0] rsp_byte, // Device byte
  input wire logic [7:0] node_address, // Node register
  input wire logic [7:0] group_identifier, // Group register
  input wire logic frame_good, // Accept pulse
  input wire logic frame_error // Check failure pulse
);
  logic [4:0] crem; // Command bytes still due
  logic [7:0] rrem; // Reply bytes still due
  logic [15:0] ccrc; // Command residue
  logic [15:0] rcrc; // Reply residue
  logic [4:0] clen; // Command length from init byte
  // One byte through the reflected check code
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    return c;
  endfunction : fold
  // Length: init, id unless bit 6, address, payload, two check bytes
  assign clen = 5'h3 + (cmd_byte[6] ? 5'h0 : 5'h1) + (cmd_byte[3] ? 5'h2 : 5'h1)
    + ((cmd_byte[2:0] == 3'h7) ? 5'h8 : {2'h0, cmd_byte[2:0]});
  // Frame position and residue in both directions
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      crem <= 5'h00;
      rrem <= 8'h00;
      ccrc <= 16'h0000;
      rcrc <= 16'h0000;
    end
    else
    begin
      if (cmd_valid)
      begin
        crem <= (crem == 5'h00) ? clen - 5'h1 : crem - 5'h1;
        ccrc <= fold((crem == 5'h00) ? 16'h0000 : ccrc, cmd_byte);
      end
      if (rsp_valid)
      begin
        rrem <= (rrem == 8'h00) ? {1'b0, rsp_byte[6:0]} + 8'h3 : rrem - 8'h1;
        rcrc <= fold((rrem == 8'h00) ? 16'h0000 : rcrc, rsp_byte);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_cmd_opens: assert property (cmd_valid && crem == 5'h00 |-> cmd_byte[7])
    else $error("command frame opens without command bit");
  chk_reply_opens: assert property (rsp_valid && rrem == 8'h00 |->
    !rsp_byte[7] && !$past(rsp_valid)) else $error("reply frame opens badly");
  chk_cmd_length: assert property ($fell(cmd_valid) |-> crem == 5'h00)
    else $error("command frame length differs from init byte");
  chk_reply_length: assert property ($fell(rsp_valid) |-> rrem == 8'h00)
    else $error("reply frame length differs from init byte");
  chk_cmd_residue: assert property ($fell(cmd_valid) |-> ccrc == 16'h0000)
    else $error("command frame residue nonzero");
  chk_reply_residue: assert property ($fell(rsp_valid) |-> rcrc == 16'h0000)
    else $error("reply frame residue nonzero");
  chk_reply_after_cmd: assert property ($rose(rsp_valid) |-> $past(cmd_valid, 2))
    else $error("reply started without a command two cycles before");
  chk_no_overlap: assert property (rsp_valid |-> !cmd_valid)
    else $error("command byte sent during reply");
  chk_good_cause: assert property (frame_good |->
    !frame_error && ($past(cmd_valid) || $past(cmd_valid, 2)))
    else $error("accept pulse without a frame");
  chk_reg_write: assert property ($changed(node_address) ||
    $changed(group_identifier) |-> frame_good) else $error("register changed without accept");
endmodule : framer_assertions

//--- tb/command_response_framer_tb.sv
/*
 Testbench: host register port sends frames to the device end.
 Assumes package, link, both ends and checker compiled first.
*/
`timescale 1ns/1ns
module command_response_framer_tb;
  logic clk; // Clock
  logic rstn; // Async reset, low
  logic [3:0] addr; // Host register index
  logic [31:0] wdata; // Host write data
  logic wr; // Write strobe
  logic rd; // Read strobe
  logic [31:0] rdata; // Read data
  logic [7:0] node_address; // Device node
  logic [7:0] group_identifier; // Device group
  logic frame_good; // Accept pulse
  logic frame_error; // Check failure pulse
  int miscompares; // Mismatches
  int compares; // Comparisons
  int goods; // Accept pulses seen
  logic [7:0] cq[$]; // Command bytes
  logic [7:0] rq[$]; // Reply bytes
  framer_link lnk ();
  framer_host #(.TIMEOUT_CYCLES(200)) framer_host_i (.clk(clk), .rstn(rstn), .link(lnk),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  framer_device framer_device_i (.clk(clk), .rstn(rstn), .link(lnk),
    .node_address(node_address), .group_identifier(group_identifier),
    .frame_good(frame_good), .frame_error(frame_error));
  framer_assertions framer_assertions_i (.clk(clk), .rstn(rstn), .cmd_valid(lnk.cmd_valid),
    .cmd_byte(lnk.cmd_byte), .rsp_valid(lnk.rsp_valid), .rsp_byte(lnk.rsp_byte),
    .node_address(node_address), .group_identifier(group_identifier),
    .frame_good(frame_good), .frame_error(frame_error));
  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Record link bytes and accept pulses
  always @(posedge clk)
  begin
    if (lnk.cmd_valid === 1'b1)
      cq.push_back(lnk.cmd_byte);
    if (lnk.rsp_valid === 1'b1)
      rq.push_back(lnk.rsp_byte);
    if (frame_good === 1'b1)
      goods++;
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  // Residue of a whole frame, zero when good
  function automatic logic [15:0] residue(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : residue
  // Send one frame, wait, judge the link bytes
  task automatic send(input logic [2:0] k, input logic w, input logic [2:0] l,
    input logic [31:0] t, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] s;
    int p, c;
    cq.delete();
    rq.delete();
    wr_reg(framer_pkg::TARGET_OFS, t);
    wr_reg(framer_pkg::PAY_LO_OFS, lo);
    wr_reg(framer_pkg::PAY_HI_OFS, hi);
    wr_reg(framer_pkg::CTRL_OFS, {24'h0, 1'b1, k, w, l});
    s = 32'h1;
    for (int n = 0; n < 200 && s[0] !== 1'b0; n++)
      rd_reg(framer_pkg::STATUS_OFS, s);
    repeat (2) @(posedge clk);
    c = (l == 3'h7) ? 8 : int'(l);
    p = k[2] ? 1 : 2;
    check("init byte", cq[0], {1'b1, k, w, l});
    check("cmd length", cq.size(), 3 + p + (w ? 2 : 1) + c - 1);
    if (!k[2])
      check("identifier", cq[1], t[7:0]);
    if (w)
      check("addr high", cq[p++], t[23:16]);
    check("addr low", cq[p], t[15:8]);
    for (int i = 0; i < c; i++)
      check("payload", cq[p + 1 + i], 8'((i < 4) ? lo >> (8 * i) : hi >> (8 * i - 32)));
    check("cmd residue", residue(cq), 16'h0);
    if (rq.size() > 0)
    begin
      check("reply kind", rq[0][7], 1'b0);
      check("reply length", rq.size(), rq[0][6:0] + 4);
      check("reply residue", residue(rq), 16'h0);
    end
  endtask : send
  task automatic t_reset();
    logic [31:0] d;
    check("node reset", node_address, 8'h00);
    check("group reset", group_identifier, 8'h00);
    rd_reg(4'hF, d);
    check("unmapped", d, 32'h0);
    check("no reply", rq.size(), 0);
    $display("Test reset done");
  endtask : t_reset
  task automatic t_write();
    send(3'h1, 1'b0, 3'h1, 32'h00000A00, 32'h05, 32'h0);
    check("init 91", cq[0], 8'h91);
    check("node write", node_address, 8'h05);
    check("accepted", goods, 1);
    check("quiet", rq.size(), 0);
    send(3'h7, 1'b1, 3'h1, 32'h00000BEE, 32'h44, 32'h0);
    check("bcast group", group_identifier, 8'h44);
    $display("Test write done");
  endtask : t_write
  task automatic t_read();
    logic [31:0] d;
    send(3'h0, 1'b0, 3'h1, 32'h00000A05, 32'h01, 32'h0);
    check("reply init", rq[0], 8'h01);
    check("node still", node_address, 8'h05);
    rd_reg(framer_pkg::STATUS_OFS, d);
    check("status", d[14:0], 15'h0102);
    rd_reg(framer_pkg::REPLY_LO_OFS, d);
    check("reply data", d[15:0], 16'h4405);
    $display("Test read done");
  endtask : t_read
  task automatic t_match();
    send(3'h1, 1'b0, 3'h1, 32'h00000A33, 32'h77, 32'h0);
    send(3'h3, 1'b0, 3'h1, 32'h00000A45, 32'h77, 32'h0);
    check("mismatch", node_address, 8'h05);
    check("no accept", goods, 3);
    send(3'h3, 1'b0, 3'h1, 32'h00000A44, 32'h09, 32'h0);
    check("group write", node_address, 8'h09);
    send(3'h2, 1'b0, 3'h0, 32'h00000A44, 32'h0, 32'h0);
    check("group read", rq[1], 8'h09);
    send(3'h6, 1'b0, 3'h0, 32'h00000B00, 32'h0, 32'h0);
    check("bcast read", rq[1], 8'h44);
    $display("Test match done");
  endtask : t_match
  task automatic t_long();
    logic [31:0] d;
    send(3'h7, 1'b0, 3'h7, 32'h0, 32'h04030201, 32'h08070605);
    send(3'h0, 1'b0, 3'h1, 32'h00000009, 32'h07, 32'h0);
    check("reply count", rq.size(), 11);
    rd_reg(framer_pkg::REPLY_LO_OFS, d);
    check("reply lo", d, 32'h04030201);
    rd_reg(framer_pkg::REPLY_HI_OFS, d);
    check("reply hi", d, 32'h08070605);
    $display("Test long done");
  endtask : t_long
  task automatic t_reserved();
    logic [31:0] d;
    for (int k = 4; k < 6; k++)
    begin
      send(k[2:0], 1'b0, 3'h1, 32'h00000A00, 32'hAA, 32'h0);
      check("dropped", node_address, 8'h09);
      check("silent", rq.size(), 0);
      rd_reg(framer_pkg::STATUS_OFS, d);
      check("timeout", d[3], !k[0]);
    end
    $display("Test reserved done");
  endtask : t_reserved
  task automatic stop_test();
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Cut a hang short
  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // Reset, then the scenarios in turn
  initial
  begin
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (3) @(posedge clk);
    #10;
    rstn = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_match();
    t_long();
    t_reserved();
    stop_test();
  end
endmodule : command_response_framer_tb
